/* File: core/sac_map.vh */
// Constants for the stack arithmetic and compare unit.
// Assumes one includer, the unit core; plain Verilog-2005 defines only.
// How it works
// - Opcode syllable, then zero to four parameters; param_count gives zero here, so no operator takes one.
// - Arguments removed, result left on top.
// - Underflow when top below record base plus argument count.
// - Overflow when pushed top equals stack limit.
// - Non-operand argument raises invalid argument.
// - Add, subtract, multiply, divide, remainder: single only when both inputs single.
// - Add opcode 80 rounds, flags exponent overflow.
// - Subtract opcode 81 second minus top.
// - Multiply opcode 82 flags overflow and underflow.
// - Extended multiply 8F always gives double.
// - Divide 83 checks zero divisor and range.
// - Integer divide 84 truncates, checks overflow.
// - Remainder 85 keeps dividend sign.
// - Sign flip 8E negates top operand.
// - Variant 8E normalizes, flags underflow.
// - Compares push integer one or zero.
// - 88 less, 89 greater, 8A greater-equal.
// - 8B less-equal, 8C equal, 8D not equal.
// - Opcode 86 integerizes by truncation.
// - Opcode 87 integerizes by rounding.
// - Stack limit bounds the overflow check.
// - Top record pointer marks expression stack base.
`ifndef SAC_MAP_VH
`define SAC_MAP_VH
`define SAC_WORD_W       48
`define SAC_ADDR_W       20
`define SAC_TAG_W        3
`define SAC_TAG_SINGLE   3'h0
`define SAC_TAG_DOUBLE   3'h2
`define SAC_INT_BITS     39
`define SAC_VARIANT_ESC  8'h95
`define SAC_OP_ADD       8'h80
`define SAC_OP_SUB       8'h81
`define SAC_OP_MUL       8'h82
`define SAC_OP_DIV       8'h83
`define SAC_OP_INTEGER_QUOTIENT_OPERATOR      8'h84
`define SAC_OP_REM       8'h85
`define SAC_OP_NTRUNC    8'h86
`define SAC_OP_NROUND    8'h87
`define SAC_OP_LT        8'h88
`define SAC_OP_GT        8'h89
`define SAC_OP_GE        8'h8A
`define SAC_OP_LE        8'h8B
`define SAC_OP_EQ        8'h8C
`define SAC_OP_NE        8'h8D
`define SAC_OP_NEG       8'h8E
`define SAC_OP_EXTENDED_PRODUCT_OPERATOR      8'h8F
`define SAC_VOP_NORMALIZING_OPERATOR     8'h8E
`endif

/* File: core/sac_unit.v */
// Stack arithmetic and compare unit: decodes operator syllables and
// executes arithmetic, relational and integerize operators.
// Assumes the sequencer presents the two top stack items, the stack
// address, record base and limit in the same clock domain.
`timescale 1ns/1ps
`include "sac_map.vh"
module sac_unit (
   // Clock and reset.
   input  wire                     mclk,
   input  wire                     rst_n,
   // Syllable stream.
   input  wire                     syl_valid,
   input  wire [7:0]               syl_data,
   // Top two stack items.
   input  wire [`SAC_WORD_W-1:0]   top_hi,
   input  wire [`SAC_WORD_W-1:0]   top_lo,
   input  wire [`SAC_TAG_W-1:0]    top_tag,
   input  wire [`SAC_WORD_W-1:0]   sec_hi,
   input  wire [`SAC_WORD_W-1:0]   sec_lo,
   input  wire [`SAC_TAG_W-1:0]    sec_tag,
   // Stack bounds.
   input  wire [`SAC_ADDR_W-1:0]   tos_addr,
   input  wire [`SAC_ADDR_W-1:0]   top_record_pointer,
   input  wire [`SAC_ADDR_W-1:0]   stack_limit_reg,
   // Result.
   output reg                      done_q,
   output reg                      push_q,
   output reg  [`SAC_WORD_W-1:0]   res_hi_q,
   output reg  [`SAC_WORD_W-1:0]   res_lo_q,
   output reg  [`SAC_TAG_W-1:0]    res_tag_q,
   output reg  [`SAC_ADDR_W-1:0]   new_tos_q,
   // Interrupt pulses.
   output reg                      stk_underflow_q,
   output reg                      stk_overflow_q,
   output reg                      invalid_arg_q,
   output reg                      exp_overflow_q,
   output reg                      exp_underflow_q,
   output reg                      int_overflow_q,
   output reg                      div_zero_q
);

////////////////////////////////////////////////////////////////////////
// Helpers.

// Value as signed fixed point: high word integer, low word fraction.
// A single operand gains an all-zero second word, value unchanged.
function [95:0] op_val;
   input [47:0] hi;
   input [47:0] lo;
   input [2:0]  tag;
   op_val = (tag == `SAC_TAG_DOUBLE) ? {hi, lo} : {hi, 48'h0};
endfunction
function is_operand;
   input [2:0] tag;
   is_operand = (tag == `SAC_TAG_SINGLE) || (tag == `SAC_TAG_DOUBLE);
endfunction
// Integer part toward zero, as a 49-bit signed value.
function [48:0] trunc_int;
   input [95:0] v;
   if (v[95] && (v[47:0] != 48'h0))
      trunc_int = {v[95], v[95:48]} + 49'h1;
   else
      trunc_int = {v[95], v[95:48]};
endfunction
// True when a 49-bit signed integer does not fit the integer range.
function int_too_big;
   input [48:0] v;
   int_too_big = (v[48:`SAC_INT_BITS] != {(49-`SAC_INT_BITS){1'b0}})
              && (v[48:`SAC_INT_BITS] != {(49-`SAC_INT_BITS){1'b1}});
endfunction

////////////////////////////////////////////////////////////////////////
// Decoder.  Every operator here carries no parameter; param_count
// returns zero for every syllable, so the counter is never loaded.

localparam ST_IDLE  = 2'b00;
localparam ST_VAR   = 2'b01;
localparam ST_PARAM = 2'b10;
reg  [1:0] state_q;
reg  [1:0] state_d;
reg  [2:0] pcnt_q;
reg  [2:0] pcnt_d;
reg        exec;
reg        exec_var;
function [2:0] param_count;
   input [7:0] op;
   param_count = 3'h0;
endfunction

always @* begin
   state_d  = state_q;
   pcnt_d   = pcnt_q;
   exec     = 1'b0;
   exec_var = 1'b0;
   case (state_q)
      ST_IDLE: begin
         if (syl_valid) begin
            if (syl_data == `SAC_VARIANT_ESC)
               state_d = ST_VAR;
            else if (param_count(syl_data) != 3'h0) begin
               pcnt_d  = param_count(syl_data);
               state_d = ST_PARAM;
            end else
               exec = 1'b1;
         end
      end
      ST_VAR: begin
         if (syl_valid) begin
            exec     = 1'b1;
            exec_var = 1'b1;
            state_d  = ST_IDLE;
         end
      end
      ST_PARAM: begin
         if (syl_valid) begin
            pcnt_d = pcnt_q - 3'h1;
            if (pcnt_q == 3'h1)
               state_d = ST_IDLE;
         end
      end
      default: state_d = ST_IDLE;
   endcase
end
////////////////////////////////////////////////////////////////////////
// Datapath.

wire [95:0] a_v = op_val(sec_hi, sec_lo, sec_tag);
wire [95:0] b_v = op_val(top_hi, top_lo, top_tag);
wire        a_ok = is_operand(sec_tag);
wire        b_ok = is_operand(top_tag);
wire        both_single = (sec_tag == `SAC_TAG_SINGLE)
                       && (top_tag == `SAC_TAG_SINGLE);
wire signed [96:0]  sum_s  = {a_v[95], a_v} + {b_v[95], b_v};
wire signed [96:0]  dif_s  = {a_v[95], a_v} - {b_v[95], b_v};
wire signed [191:0] prod_s = $signed({{96{a_v[95]}}, a_v})
                           * $signed({{96{b_v[95]}}, b_v});
wire        b_zero = (b_v == 96'h0);
wire [95:0] b_safe = b_zero ? 96'h1 : b_v;
// Quotient carries one extra fraction bit for rounding.
wire signed [144:0] quo2_s = $signed({a_v, 49'h0})
                           / $signed({{49{b_safe[95]}}, b_safe});
wire signed [95:0]  iquo_s = $signed(a_v) / $signed(b_safe);
wire signed [95:0]  rem_s  = $signed(a_v) % $signed(b_safe);
wire        lt_f = $signed(a_v) < $signed(b_v);
wire        eq_f = (a_v == b_v);
reg  [7:0]  opc;
reg  [1:0]  nargs;
reg  [95:0] r_v;
reg         r_dbl;
reg         r_int;
reg         e_inv;
reg         e_eovf;
reg         e_eunf;
reg         e_iovf;
reg         e_dz;
reg         known;
reg  [145:0] t146;
reg  [48:0] ti;
always @* begin
   opc    = syl_data;
   nargs  = 2'd2;
   r_v    = 96'h0;
   r_dbl  = ~both_single;
   r_int  = 1'b0;
   e_inv  = 1'b0;
   e_eovf = 1'b0;
   e_eunf = 1'b0;
   e_iovf = 1'b0;
   e_dz   = 1'b0;
   known  = 1'b1;
   t146   = 146'h0;
   ti     = 49'h0;
   if (exec_var) begin
      nargs = 2'd1;
      if (opc == `SAC_VOP_NORMALIZING_OPERATOR) begin
         e_inv = ~b_ok;
         r_v   = b_v;
         r_dbl = (top_tag == `SAC_TAG_DOUBLE);
         // A pure fraction has no normalized integer part here.
         e_eunf = r_dbl && (b_v[95:48] == 48'h0)
               && (b_v[47:0] != 48'h0);
      end else
         known = 1'b0;
   end else begin
      case (opc)
         `SAC_OP_ADD: begin
            e_inv = ~(a_ok & b_ok);
            r_v = sum_s[95:0];
            e_eovf = sum_s[96] ^ sum_s[95];
         end
         `SAC_OP_SUB: begin
            e_inv = ~(a_ok & b_ok);
            r_v = dif_s[95:0];
            e_eovf = dif_s[96] ^ dif_s[95];
         end
         `SAC_OP_MUL, `SAC_OP_EXTENDED_PRODUCT_OPERATOR: begin
            e_inv = ~(a_ok & b_ok);
            r_v = prod_s[143:48] + {95'h0, prod_s[47]};
            e_eovf = (prod_s[191:143] != {49{1'b0}})
                  && (prod_s[191:143] != {49{1'b1}});
            e_eunf = (prod_s != 192'h0) && (r_v == 96'h0);
            if (opc == `SAC_OP_EXTENDED_PRODUCT_OPERATOR)
               r_dbl = 1'b1;
         end
         `SAC_OP_DIV: begin
            e_inv = ~(a_ok & b_ok);
            e_dz  = b_zero;
            t146 = {quo2_s[144], quo2_s} + 146'h1;
            r_v  = t146[96:1];
            e_eovf = (t146[145:96] != {50{1'b0}})
                  && (t146[145:96] != {50{1'b1}});
            e_eunf = (a_v != 96'h0) && (r_v == 96'h0);
         end
         `SAC_OP_INTEGER_QUOTIENT_OPERATOR: begin
            e_inv = ~(a_ok & b_ok);
            e_dz  = b_zero;
            r_dbl = 1'b0;
            r_int = 1'b1;
            ti    = iquo_s[48:0];
            e_iovf = int_too_big(ti)
                  || (iquo_s[95:48] != {48{iquo_s[48]}});
         end
         `SAC_OP_REM: begin
            e_inv = ~(a_ok & b_ok);
            e_dz  = b_zero;
            r_v   = rem_s;
            e_iovf = int_too_big({rem_s[95], rem_s[95:48]});
         end
         `SAC_OP_NEG: begin
            nargs = 2'd1;
            e_inv = ~b_ok;
            r_v   = 96'h0 - b_v;
            r_dbl = (top_tag == `SAC_TAG_DOUBLE);
         end
         `SAC_OP_NTRUNC, `SAC_OP_NROUND: begin
            nargs = 2'd1;
            e_inv = ~b_ok;
            r_dbl = 1'b0;
            r_int = 1'b1;
            if (opc == `SAC_OP_NROUND)
               ti = trunc_int(b_v + (b_v[95] ? 96'hFFFFFFFFFFFF800000000000
                                             : 96'h000000000000800000000000));
            else
               ti = trunc_int(b_v);
            e_iovf = int_too_big(ti);
         end
         `SAC_OP_LT, `SAC_OP_GT, `SAC_OP_GE,
         `SAC_OP_LE, `SAC_OP_EQ, `SAC_OP_NE: begin
            e_inv = ~(a_ok & b_ok);
            r_dbl = 1'b0;
            r_int = 1'b1;
            case (opc)
               `SAC_OP_LT: ti = {48'h0, lt_f};
               `SAC_OP_GT: ti = {48'h0, ~lt_f & ~eq_f};
               `SAC_OP_GE: ti = {48'h0, ~lt_f};
               `SAC_OP_LE: ti = {48'h0, lt_f | eq_f};
               `SAC_OP_EQ: ti = {48'h0, eq_f};
               default:    ti = {48'h0, ~eq_f};
            endcase
         end
         default: known = 1'b0;
      endcase
   end
end
////////////////////////////////////////////////////////////////////////
// Stack checks and result register.

// The last argument sits nargs-1 below the top; it must not reach the
// linkage word at the record base.
wire [`SAC_ADDR_W:0] need_addr = {1'b0, top_record_pointer}
                               + {{(`SAC_ADDR_W-1){1'b0}}, nargs};
wire        under = ({1'b0, tos_addr} < need_addr);
wire [`SAC_ADDR_W-1:0] push_addr = tos_addr
                               - {{(`SAC_ADDR_W-2){1'b0}}, nargs}
                               + {{(`SAC_ADDR_W-1){1'b0}}, 1'b1};
wire        fault = under | e_inv | e_dz | e_eovf | e_eunf | e_iovf;
// Rounded single result: integer part plus the fraction's top bit.
wire [47:0] r_single = r_v[95:48] + {47'h0, r_v[47]};
always @(posedge mclk or negedge rst_n) begin
   if (!rst_n) begin
      state_q         <= ST_IDLE;
      pcnt_q          <= 3'h0;
      done_q          <= 1'b0;
      push_q          <= 1'b0;
      res_hi_q        <= 48'h0;
      res_lo_q        <= 48'h0;
      res_tag_q       <= `SAC_TAG_SINGLE;
      new_tos_q       <= {`SAC_ADDR_W{1'b0}};
      stk_underflow_q <= 1'b0;
      stk_overflow_q  <= 1'b0;
      invalid_arg_q   <= 1'b0;
      exp_overflow_q  <= 1'b0;
      exp_underflow_q <= 1'b0;
      int_overflow_q  <= 1'b0;
      div_zero_q      <= 1'b0;
   end else begin
      state_q         <= state_d;
      pcnt_q          <= pcnt_d;
      done_q          <= exec;
      push_q          <= 1'b0;
      stk_underflow_q <= 1'b0;
      stk_overflow_q  <= 1'b0;
      invalid_arg_q   <= 1'b0;
      exp_overflow_q  <= 1'b0;
      exp_underflow_q <= 1'b0;
      int_overflow_q  <= 1'b0;
      div_zero_q      <= 1'b0;
      if (exec && known) begin
         // Underflow is judged first; later faults need valid items.
         stk_underflow_q <= under;
         invalid_arg_q   <= ~under & e_inv;
         div_zero_q      <= ~under & ~e_inv & e_dz;
         exp_overflow_q  <= ~under & ~e_inv & ~e_dz & e_eovf;
         exp_underflow_q <= ~under & ~e_inv & ~e_dz & e_eunf;
         int_overflow_q  <= ~under & ~e_inv & ~e_dz & e_iovf;
         new_tos_q       <= fault ? tos_addr : push_addr;
         if (!fault) begin
            push_q <= 1'b1;
            stk_overflow_q <= (push_addr == stack_limit_reg);
            if (r_int) begin
               res_hi_q  <= ti[47:0];
               res_lo_q  <= 48'h0;
               res_tag_q <= `SAC_TAG_SINGLE;
            end else if (r_dbl) begin
               res_hi_q  <= r_v[95:48];
               res_lo_q  <= r_v[47:0];
               res_tag_q <= `SAC_TAG_DOUBLE;
            end else begin
               res_hi_q  <= r_single;
               res_lo_q  <= 48'h0;
               res_tag_q <= `SAC_TAG_SINGLE;
            end
         end
      end else if (exec)
         new_tos_q <= tos_addr;
   end
end

endmodule // sac_unit

/* File: verification/sac_seq_model.sv */
// Sequencer and stack model: presents syllables and the two top items.
// Assumes the unit samples its inputs on the rising edge of mclk.
`timescale 1ns/1ps
module sac_seq_model (
   // Clock.
   input  wire        mclk,
   // Syllables and stack state presented to the unit.
   output reg         syl_valid,
   output reg  [7:0]  syl_data,
   output reg  [47:0] top_hi,
   output reg  [47:0] top_lo,
   output reg  [2:0]  top_tag,
   output reg  [47:0] sec_hi,
   output reg  [47:0] sec_lo,
   output reg  [2:0]  sec_tag,
   output reg  [19:0] tos_addr,
   output reg  [19:0] top_record_pointer,
   output reg  [19:0] stack_limit_reg
);
   task frame(input [19:0] s, input [19:0] b, input [19:0] l);
      begin
         tos_addr = s;
         top_record_pointer = b;
         stack_limit_reg = l;
      end
   endtask
   task load(input [47:0] sh, input [47:0] sl, input [2:0] st,
      input [47:0] th, input [47:0] tl, input [2:0] tt);
      begin
         {sec_hi, sec_lo, sec_tag} = {sh, sl, st};
         {top_hi, top_lo, top_tag} = {th, tl, tt};
      end
   endtask
   // One syllable per call; a variant operator takes two; none used here takes parameters.
   task issue(input [7:0] op);
      begin
         @(negedge mclk);
         syl_valid = 1'b1;
         syl_data = op;
         @(negedge mclk);
         syl_valid = 1'b0;
         // A released byte must not keep showing the last value.
         syl_data = ~op;
      end
   endtask
   initial begin
      syl_valid = 1'b0;
      syl_data = 8'h00;
      frame(20'h64, 20'hA, 20'hC8);
      load(48'h0, 48'h0, 3'h0, 48'h0, 48'h0, 3'h0);
   end
endmodule // sac_seq_model

/* File: verification/sac_unit_checker.sv */
// Checker for the stack arithmetic unit, bound to its ports.
// Assumes one clock and an active-low asynchronous reset.
`timescale 1ns/1ps
module sac_unit_checker (
   // Clock and reset.
   input wire        mclk,
   input wire        rst_n,
   // Syllables, tags and stack bounds.
   input wire        syl_valid,
   input wire [7:0]  syl_data,
   input wire [47:0] top_hi,
   input wire [47:0] top_lo,
   input wire [2:0]  top_tag,
   input wire [2:0]  sec_tag,
   input wire [19:0] tos_addr,
   input wire [19:0] top_record_pointer,
   input wire [19:0] stack_limit_reg,
   // Results and fault pulses.
   input wire        done_q,
   input wire        push_q,
   input wire [47:0] res_hi_q,
   input wire [47:0] res_lo_q,
   input wire [2:0]  res_tag_q,
   input wire [19:0] new_tos_q,
   input wire        stk_underflow_q,
   input wire        stk_overflow_q,
   input wire        invalid_arg_q,
   input wire        div_zero_q
);
   reg var_q;
   wire ex = syl_valid && (var_q || syl_data != 8'h95);
   wire pl = !var_q;
   wire bin = pl && syl_data[7:4] == 4'h8 && syl_data != 8'h86 &&
      syl_data != 8'h87 && syl_data != 8'h8E;
   wire cmp = pl && syl_data >= 8'h88 && syl_data <= 8'h8D;
   wire ar4 = pl && syl_data[7:2] == 6'h20;
   wire uf2 = {1'b0, tos_addr} < {1'b0, top_record_pointer} + 21'h2;
   wire opt = top_tag == 3'h0 || top_tag == 3'h2;
   wire ops = sec_tag == 3'h0 || sec_tag == 3'h2;
   wire dz = pl && syl_data >= 8'h83 && syl_data <= 8'h85 && !uf2 &&
      opt && ops && top_hi == 48'h0 && top_lo == 48'h0;
   // Shadow of the escape state so variant codes are not taken as plain.
   always @(posedge mclk or negedge rst_n)
      if (!rst_n)
         var_q <= 1'b0;
      else if (syl_valid)
         var_q <= !var_q && syl_data == 8'h95;
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_n);
   a_done_latency: assert property (ex |=> done_q)
      else $error("done missing after syllable");
   a_done_cause: assert property (done_q |-> $past(ex))
      else $error("done without syllable");
   a_bin_pops: assert property (ex && bin ##1 push_q |->
      new_tos_q == $past(tos_addr) - 20'h1) else $error("bad new top");
   a_underflow_seen: assert property (ex && bin && uf2 |=>
      stk_underflow_q && !push_q && new_tos_q == $past(tos_addr, 1))
      else $error("underflow missed");
   a_overflow_exact: assert property (done_q |-> stk_overflow_q ==
      (push_q && new_tos_q == $past(stack_limit_reg)))
      else $error("overflow flag wrong");
   a_invalid_arg: assert property (ex && bin && !uf2 && !(opt && ops)
      |=> invalid_arg_q && !push_q) else $error("invalid arg missed");
   a_result_prec: assert property (ex && ar4 ##1 push_q |->
      res_tag_q == ($past(top_tag) | $past(sec_tag)))
      else $error("wrong precision");
   a_extended_product_operator_double: assert property (ex && pl && syl_data == 8'h8F
      ##1 push_q |-> res_tag_q == 3'h2) else $error("extended not double");
   a_div_zero: assert property (ex && dz |=> div_zero_q && !push_q)
      else $error("divide by zero missed");
   a_cmp_bool: assert property (ex && cmp ##1 push_q |->
      res_tag_q == 3'h0 && res_lo_q == 48'h0 && res_hi_q[47:1] == 47'h0)
      else $error("compare not boolean");
   c_overflow: cover property (push_q && stk_overflow_q);
   c_fault: cover property (done_q && !push_q);
   c_variant: cover property (ex && !pl);
endmodule // sac_unit_checker

/* File: verification/sac_unit_tb.sv */
// Self-checking bench for the stack arithmetic unit.
// Assumes the sequencer model drives every unit input except clock and reset.
`timescale 1ns/1ps
module sac_unit_tb;
   localparam [8:0]  F_OK = 9'h180;
   localparam [17:0] CMP_TAB = {6'h26, 6'h1C, 6'h29};
   reg         mclk = 1'b0;
   reg         rst_n = 1'b0;
   integer     mismatches = 0;
   integer     cmp_count = 0;
   integer     cyc = 0;
   integer     i;
   integer     j;
   wire        syl_valid, done_q, push_q;
   wire        stk_underflow_q, stk_overflow_q, invalid_arg_q;
   wire        exp_overflow_q, exp_underflow_q, int_overflow_q, div_zero_q;
   wire [7:0]  syl_data;
   wire [47:0] top_hi, top_lo, sec_hi, sec_lo, res_hi_q, res_lo_q;
   wire [2:0]  top_tag, sec_tag, res_tag_q;
   wire [19:0] tos_addr, top_record_pointer, stack_limit_reg, new_tos_q;
   wire [8:0]  flags = {done_q, push_q, stk_underflow_q, stk_overflow_q,
      invalid_arg_q, exp_overflow_q, exp_underflow_q, int_overflow_q,
      div_zero_q};
   sac_unit u_sac_unit (
      .mclk(mclk), .rst_n(rst_n), .syl_valid(syl_valid),
      .syl_data(syl_data), .top_hi(top_hi), .top_lo(top_lo),
      .top_tag(top_tag), .sec_hi(sec_hi), .sec_lo(sec_lo),
      .sec_tag(sec_tag), .tos_addr(tos_addr),
      .top_record_pointer(top_record_pointer),
      .stack_limit_reg(stack_limit_reg), .done_q(done_q),
      .push_q(push_q), .res_hi_q(res_hi_q), .res_lo_q(res_lo_q),
      .res_tag_q(res_tag_q), .new_tos_q(new_tos_q),
      .stk_underflow_q(stk_underflow_q), .stk_overflow_q(stk_overflow_q),
      .invalid_arg_q(invalid_arg_q), .exp_overflow_q(exp_overflow_q),
      .exp_underflow_q(exp_underflow_q), .int_overflow_q(int_overflow_q),
      .div_zero_q(div_zero_q));
   sac_seq_model u_sac_seq_model (
      .mclk(mclk), .syl_valid(syl_valid), .syl_data(syl_data),
      .top_hi(top_hi), .top_lo(top_lo), .top_tag(top_tag),
      .sec_hi(sec_hi), .sec_lo(sec_lo), .sec_tag(sec_tag),
      .tos_addr(tos_addr), .top_record_pointer(top_record_pointer),
      .stack_limit_reg(stack_limit_reg));
   always #10 mclk = ~mclk;
   always @(posedge mclk) begin
      cyc = cyc + 1;
      if (cyc == 3000) begin
         mismatches = mismatches + 1;
         end_sim;
      end
   end
   task end_sim;
      begin
         if (mismatches == 0 && cmp_count > 0)
            $display("Run complete: PASS");
         else
            $display("Run complete: FAIL");
         $finish;
      end
   endtask
   task chk_val(input [47:0] got, input [47:0] exp);
      begin
         cmp_count = cmp_count + 1;
         if (got !== exp) begin
            mismatches = mismatches + 1;
            $display("BAD %0t value %h want %h", $time, got, exp);
         end
      end
   endtask
   task chk_flags(input [8:0] got, input [8:0] exp);
      begin
         cmp_count = cmp_count + 1;
         if (got !== exp) begin
            mismatches = mismatches + 1;
            $display("BAD %0t flags %h want %h", $time, got, exp);
         end
      end
   endtask
   task ld1(input [47:0] a, input [47:0] b);
      u_sac_seq_model.load(a, 48'h0, 3'h0, b, 48'h0, 3'h0);
   endtask
   task run(input [7:0] op, input [8:0] f, input [47:0] hi,
      input [2:0] tg, input [19:0] nt);
      begin
         u_sac_seq_model.issue(op);
         chk_flags(flags, f);
         chk_val({28'h0, new_tos_q}, {28'h0, nt});
         if (f[7]) begin
            chk_val(res_hi_q, hi);
            chk_val({45'h0, res_tag_q}, {45'h0, tg});
         end
      end
   endtask
   task t_arith;
      begin
         ld1(48'h5, 48'h7);
         run(8'h80, F_OK, 48'hC, 3'h0, 20'h63);
         run(8'h81, F_OK, 48'hFFFFFFFFFFFE, 3'h0, 20'h63);
         run(8'h82, F_OK, 48'h23, 3'h0, 20'h63);
         run(8'h8F, F_OK, 48'h23, 3'h2, 20'h63);
         ld1(48'h7FFFFFFFFFFF, 48'h1);
         run(8'h80, 9'h108, 48'h0, 3'h0, 20'h64);
         u_sac_seq_model.load(48'h0, 48'h1, 3'h2, 48'h0, 48'h1, 3'h2);
         run(8'h82, 9'h104, 48'h0, 3'h0, 20'h64);
         u_sac_seq_model.load(48'h1, 48'h800000000000, 3'h2, 48'h2, 48'h0,
            3'h0);
         run(8'h80, F_OK, 48'h3, 3'h2, 20'h63);
         chk_val(res_lo_q, 48'h800000000000);
         ld1(48'h2A, 48'h6);
         run(8'h83, F_OK, 48'h7, 3'h0, 20'h63);
         ld1(48'hFFFFFFFFFFF9, 48'h2);
         run(8'h84, F_OK, 48'hFFFFFFFFFFFD, 3'h0, 20'h63);
         run(8'h85, F_OK, 48'hFFFFFFFFFFFF, 3'h0, 20'h63);
      end
   endtask
   task t_faults;
      begin
         ld1(48'h5, 48'h0);
         for (i = 0; i < 3; i = i + 1)
            run(8'h83 + i[7:0], 9'h101, 48'h0, 3'h0, 20'h64);
         u_sac_seq_model.load(48'h5, 48'h0, 3'h0, 48'h1, 48'h0, 3'h5);
         run(8'h80, 9'h110, 48'h0, 3'h0, 20'h64);
         ld1(48'h0, 48'h5);
         u_sac_seq_model.frame(20'hB, 20'hA, 20'hC8);
         run(8'h80, 9'h140, 48'h0, 3'h0, 20'hB);
         run(8'h8E, F_OK, 48'hFFFFFFFFFFFB, 3'h0, 20'hB);
         u_sac_seq_model.frame(20'h64, 20'hA, 20'h63);
         run(8'h80, 9'h1A0, 48'h5, 3'h0, 20'h63);
         u_sac_seq_model.frame(20'h64, 20'hA, 20'hC8);
         ld1(48'h0, 48'h008000000000);
         run(8'h86, 9'h102, 48'h0, 3'h0, 20'h64);
         run(8'h20, 9'h100, 48'h0, 3'h0, 20'h64);
      end
   endtask
   task t_unary;
      begin
         u_sac_seq_model.load(48'h0, 48'h0, 3'h0, 48'h2, 48'h800000000000,
            3'h2);
         run(8'h86, F_OK, 48'h2, 3'h0, 20'h64);
         run(8'h87, F_OK, 48'h3, 3'h0, 20'h64);
         u_sac_seq_model.issue(8'h95);
         chk_flags(flags, 9'h000);
         run(8'h8E, F_OK, 48'h2, 3'h2, 20'h64);
         u_sac_seq_model.load(48'h0, 48'h0, 3'h0, 48'h0, 48'h1, 3'h2);
         u_sac_seq_model.issue(8'h95);
         run(8'h8E, 9'h104, 48'h0, 3'h0, 20'h64);
         u_sac_seq_model.load(48'h0, 48'h0, 3'h0, 48'h5, 48'h0, 3'h5);
         u_sac_seq_model.issue(8'h95);
         run(8'h8E, 9'h110, 48'h0, 3'h0, 20'h64);
      end
   endtask
   task t_compare;
      for (j = 0; j < 3; j = j + 1)
         for (i = 0; i < 6; i = i + 1) begin
            ld1(48'h3 + 2 * j, 48'h5);
            run(8'h88 + i[7:0], F_OK, {47'h0, CMP_TAB[6 * j + i]}, 3'h0,
               20'h63);
         end
   endtask
   initial begin
      repeat (2) @(posedge mclk);
      @(negedge mclk);
      rst_n = 1'b1;
      t_arith;
      t_faults;
      t_unary;
      t_compare;
      end_sim;
   end
endmodule // sac_unit_tb
bind sac_unit sac_unit_checker u_sac_unit_checker (
   .mclk(mclk), .rst_n(rst_n), .syl_valid(syl_valid), .syl_data(syl_data),
   .top_hi(top_hi), .top_lo(top_lo), .top_tag(top_tag), .sec_tag(sec_tag),
   .tos_addr(tos_addr), .top_record_pointer(top_record_pointer),
   .stack_limit_reg(stack_limit_reg), .done_q(done_q), .push_q(push_q),
   .res_hi_q(res_hi_q), .res_lo_q(res_lo_q), .res_tag_q(res_tag_q),
   .new_tos_q(new_tos_q), .stk_underflow_q(stk_underflow_q),
   .stk_overflow_q(stk_overflow_q), .invalid_arg_q(invalid_arg_q),
   .div_zero_q(div_zero_q));
